// ---- design/mdci_regs.svh ----
// Register addresses, field positions, frame constants and reset values of the command interface.
`ifndef MDCI_REGS_SVH
`define MDCI_REGS_SVH

// Register addresses reached through write-multiple frames.
`define MDCI_ADDR_COMMAND_WORD   16'h2000
`define MDCI_ADDR_FREQ_SETPOINT  16'h2001
`define MDCI_ADDR_CONTROL_FLAGS  16'h2002
`define MDCI_ADDR_STATUS_WORD    16'h2100

// Command word fields.
`define MDCI_CMD_RUN_LSB         0
`define MDCI_CMD_DIR_LSB         4
`define MDCI_CMD_RAMP_LSB        6
`define MDCI_CMD_STEP_LSB        8
`define MDCI_CMD_FIELD_ENABLE    12

// Control flag word fields.
`define MDCI_FLAG_EXT_FAULT      0
`define MDCI_FLAG_FAULT_RESET    1
`define MDCI_FLAG_BASE_BLOCK     2

// Frame layout and check constants.
`define MDCI_FUNC_WRITE_MULTI    8'h10
`define MDCI_HEADER_BYTES        7
`define MDCI_MAX_WORDS           20
`define MDCI_CRC_PRESET          16'hffff
`define MDCI_CRC_POLY            16'ha001
`define MDCI_CHAR_START          8'h3a
`define MDCI_CHAR_CR             8'h0d
`define MDCI_CHAR_LF             8'h0a

// Reset values.
`define MDCI_RESET_WORD          16'h0000
`define MDCI_RESET_BYTE          8'h00

`endif

// ---- design/mdci_pkg.sv ----
// Types shared by the command interface modules.
package mdci_pkg;

  typedef enum logic [2:0] {
    ST_RECV,
    ST_CHECK,
    ST_APPLY,
    ST_CALC,
    ST_REPLY
  } mdci_state_t;

  // One decoded frame byte with its framing marks.
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       start;
    logic       last;
    logic       err;
  } mdci_rx_byte_t;

  // Decoded drive controls.
  typedef struct packed {
    logic [15:0] commandWord;
    logic        runEnable;
    logic        inchRun;
    logic        backwardRotation;
    logic [1:0]  rampSet;
    logic [3:0]  stepSpeed;
    logic [15:0] frequencySetpoint;
    logic        externalFault;
    logic        faultReset;
    logic        baseBlock;
  } mdci_drive_ctl_t;

endpackage

// ---- design/mdci_crc16.sv ----
// Byte-wide check register engine for RTU frames.
`timescale 1ns/1ps
`default_nettype none
`include "mdci_regs.svh"

module mdci_crc16 (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Byte feed
  input  wire logic        init,
  input  wire logic        byteValid,
  input  wire logic [7:0]  byteData,
  // Running check value
  output logic      [15:0] crc
);

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  function automatic logic [15:0] crcStep(input logic [15:0] seed, input logic [7:0] b);
    logic [15:0] c;
    c = seed ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ `MDCI_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  always_comb begin
    crc_next = crc_reg;
    if (byteValid) begin
      crc_next = crcStep(init ? `MDCI_CRC_PRESET : crc_reg, byteData);
    end else if (init) begin
      crc_next = `MDCI_CRC_PRESET;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      crc_reg <= `MDCI_CRC_PRESET;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc = crc_reg;

endmodule
`default_nettype wire

// ---- design/mdci_ascii_rx.sv ----
// Receive framer: passes RTU bytes through, or pairs ASCII hex characters into bytes.
`timescale 1ns/1ps
`default_nettype none
`include "mdci_regs.svh"

module mdci_ascii_rx (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // Mode
  input  wire logic                   asciiMode,
  // Character stream
  input  wire logic [7:0]             rxChar,
  input  wire logic                   rxCharValid,
  input  wire logic                   rxGap,
  // Framed bytes
  output mdci_pkg::mdci_rx_byte_t     rxByte
);

  mdci_pkg::mdci_rx_byte_t out_reg;
  mdci_pkg::mdci_rx_byte_t out_next;
  logic                    inFrame_reg;
  logic                    inFrame_next;
  logic                    half_reg;
  logic                    half_next;
  logic [3:0]              hi_reg;
  logic [3:0]              hi_next;
  logic [4:0]              nib;

  // Bit 4 flags a character that is not a hex digit.
  always_comb begin
    nib = 5'h10;
    if (rxChar >= 8'h30 && rxChar <= 8'h39) nib = {1'b0, rxChar[3:0]};
    else if ((rxChar >= 8'h41 && rxChar <= 8'h46) || (rxChar >= 8'h61 && rxChar <= 8'h66))
      nib = {1'b0, 4'(rxChar[3:0] + 4'h9)};
  end

  always_comb begin
    out_next     = '0;
    inFrame_next = inFrame_reg;
    half_next    = half_reg;
    hi_next      = hi_reg;
    if (!asciiMode) begin
      out_next.data  = rxChar;
      out_next.valid = rxCharValid;
      out_next.last  = rxGap;
    end else if (rxCharValid) begin
      if (rxChar == `MDCI_CHAR_START) begin
        out_next.start = 1'b1;
        inFrame_next   = 1'b1;
        half_next      = 1'b0;
      end else if (inFrame_reg) begin
        if (rxChar == `MDCI_CHAR_LF) begin
          out_next.last = 1'b1;
          out_next.err  = half_reg;
          inFrame_next  = 1'b0;
        end else if (rxChar != `MDCI_CHAR_CR) begin
          if (nib[4]) begin
            out_next.err = 1'b1;
          end else if (!half_reg) begin
            hi_next   = nib[3:0];
            half_next = 1'b1;
          end else begin
            out_next.data  = {hi_reg, nib[3:0]};
            out_next.valid = 1'b1;
            half_next      = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_reg     <= '0;
      inFrame_reg <= 1'b0;
      half_reg    <= 1'b0;
      hi_reg      <= 4'h0;
    end else begin
      out_reg     <= out_next;
      inFrame_reg <= inFrame_next;
      half_reg    <= half_next;
      hi_reg      <= hi_next;
    end
  end

  assign rxByte = out_reg;

endmodule
`default_nettype wire

// ---- design/mdci_top.sv ----
// Serial slave command interpreter of a motor drive: write-multiple frames to drive registers.
//
// Notes on behaviour
// - RTU write-multiple: address, 10H, start, count, byte count, data high first, check.
// - ASCII check is negated byte sum from address to last data byte.
// - RTU check register starts at all ones before the first byte.
// - Each byte is XORed into the low byte of the check register.
// - Shift right zero fill; if a one fell out, XOR the reflected polynomial.
// - Eight shifts per byte; final register value is the check value.
// - RTU check value goes out low byte first, high byte second.
// - Parameter address: high byte is group, low byte is number within group.
// - Command bits 5..4: none, forward, reverse, change direction; bits 3..2 reserved.
// - Command bits 7..6 pick one of four ramp sets.
// - Command bits 11..8: zero is master speed, else one of fifteen step speeds.
// - Ramp and step fields act only when bit 12 is set.
// - Control flags: bit 0 external fault, bit 1 fault reset, bit 2 base block.
// - Status word holds warning code high byte, fault code low byte.
// - One write-multiple request carries at most twenty words.
`timescale 1ns/1ps
`default_nettype none
`include "mdci_regs.svh"

module mdci_top #(
  parameter int MAX_WORDS = `MDCI_MAX_WORDS
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // Configuration
  input  wire logic                    asciiMode,
  input  wire logic [7:0]              stationAddress,
  // Receive character stream
  input  wire logic [7:0]              rxChar,
  input  wire logic                    rxCharValid,
  input  wire logic                    rxGap,
  // Transmit character stream
  output logic      [7:0]              txChar,
  output logic                         txValid,
  input  wire logic                    txReady,
  // Drive state in
  input  wire logic [7:0]              warningCode,
  input  wire logic [7:0]              faultCode,
  // Drive controls out
  output mdci_pkg::mdci_drive_ctl_t    driveCtl,
  output logic      [15:0]             statusWord,
  // Parameter writes
  output logic                         paramWrite,
  output logic      [7:0]              paramGroup,
  output logic      [7:0]              paramIndex,
  output logic      [15:0]             paramData,
  // Frame outcome
  output logic                         frameAccepted,
  output logic                         frameRejected
);

  localparam int AW = $clog2(MAX_WORDS + 1);

  mdci_pkg::mdci_rx_byte_t rxB;
  logic [15:0]             crc;
  logic                    crcInit;
  logic                    crcValid;
  logic [7:0]              crcByte;

  mdci_pkg::mdci_state_t   state_reg, state_next;
  logic [5:0]              idx_reg, idx_next;
  logic                    bad_reg, bad_next;
  logic [7:0]              addr_reg, addr_next;
  logic [7:0]              func_reg, func_next;
  logic [15:0]             start_reg, start_next;
  logic [15:0]             count_reg, count_next;
  logic [7:0]              bcnt_reg, bcnt_next;
  logic [15:0]             chk_reg, chk_next;
  logic [7:0]              lrc_reg, lrc_next;
  logic [15:0]             buf_reg [MAX_WORDS];
  logic [15:0]             buf_next [MAX_WORDS];
  logic [AW-1:0]           applyIdx_reg, applyIdx_next;
  logic [4:0]              step_reg, step_next;
  logic [7:0]              txChar_reg, txChar_next;
  logic                    txValid_reg, txValid_next;
  logic                    acc_reg, acc_next;
  logic                    rej_reg, rej_next;

  mdci_ascii_rx u_rx (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .asciiMode   (asciiMode),
    .rxChar      (rxChar),
    .rxCharValid (rxCharValid),
    .rxGap       (rxGap),
    .rxByte      (rxB)
  );

  mdci_crc16 u_crc (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .init      (crcInit),
    .byteValid (crcValid),
    .byteData  (crcByte),
    .crc       (crc)
  );

  logic [8:0] bodyEnd;
  logic [8:0] idxWide;
  logic [8:0] chkPos;
  logic [5:0] dataPos;
  logic [4:0] lastStep;
  logic [7:0] lrcValue;
  logic       frameOk;

  assign bodyEnd  = 9'(`MDCI_HEADER_BYTES) + {1'b0, bcnt_reg};
  assign idxWide  = {3'b000, idx_reg};
  assign chkPos   = idxWide - bodyEnd;
  assign dataPos  = idx_reg - 6'(`MDCI_HEADER_BYTES);
  assign lrcValue = 8'(-lrc_reg);
  assign lastStep = asciiMode ? 5'h10 : 5'h07;

  // Byte i of the answer; index 6 and 7 are the check bytes.
  function automatic logic [7:0] replyByte(input logic [3:0] i);
    case (i)
      4'h0:    replyByte = addr_reg;
      4'h1:    replyByte = func_reg;
      4'h2:    replyByte = start_reg[15:8];
      4'h3:    replyByte = start_reg[7:0];
      4'h4:    replyByte = count_reg[15:8];
      4'h5:    replyByte = count_reg[7:0];
      4'h6:    replyByte = asciiMode ? lrcValue : crc[7:0];
      default: replyByte = crc[15:8];
    endcase
  endfunction

  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Character sent at a given step of the answer.
  function automatic logic [7:0] replyChar(input logic [4:0] s);
    logic [4:0] k;
    logic [7:0] b;
    k = s - 5'h01;
    b = replyByte(k[4:1]);
    if (!asciiMode) replyChar = replyByte(s[3:0]);
    else if (s == 5'h00) replyChar = `MDCI_CHAR_START;
    else if (s == 5'h0f) replyChar = `MDCI_CHAR_CR;
    else if (s == 5'h10) replyChar = `MDCI_CHAR_LF;
    else replyChar = hexChar(k[0] ? b[3:0] : b[7:4]);
  endfunction

  // Everything a request must satisfy before any register is touched.
  always_comb begin
    frameOk = !bad_reg && addr_reg == stationAddress
              && func_reg == `MDCI_FUNC_WRITE_MULTI
              && count_reg != 16'h0000 && count_reg <= 16'(MAX_WORDS)
              && {8'h00, bcnt_reg} == {count_reg[14:0], 1'b0}
              && chkPos == (asciiMode ? 9'h001 : 9'h002);
    if (asciiMode) frameOk = frameOk && chk_reg[7:0] == lrcValue;
    else frameOk = frameOk && chk_reg == crc;
  end

  always_comb begin
    state_next    = state_reg;
    idx_next      = idx_reg;
    bad_next      = bad_reg;
    addr_next     = addr_reg;
    func_next     = func_reg;
    start_next    = start_reg;
    count_next    = count_reg;
    bcnt_next     = bcnt_reg;
    chk_next      = chk_reg;
    lrc_next      = lrc_reg;
    buf_next      = buf_reg;
    applyIdx_next = applyIdx_reg;
    step_next     = step_reg;
    txChar_next   = txChar_reg;
    txValid_next  = txValid_reg;
    acc_next      = 1'b0;
    rej_next      = 1'b0;
    crcInit       = 1'b0;
    crcValid      = 1'b0;
    crcByte       = rxB.data;
    case (state_reg)
      mdci_pkg::ST_RECV: begin
        if (rxB.err) bad_next = 1'b1;
        if (rxB.start) begin
          idx_next = 6'h00;
          bad_next = 1'b0;
        end else if (rxB.last) begin
          if (idx_reg != 6'h00) state_next = mdci_pkg::ST_CHECK;
        end else begin
          if (rxB.valid) begin
            if (idx_reg < 6'(`MDCI_HEADER_BYTES) || idxWide < bodyEnd) begin
              crcInit  = (idx_reg == 6'h00);
              crcValid = 1'b1;
              lrc_next = (idx_reg == 6'h00) ? rxB.data : 8'(lrc_reg + rxB.data);
              case (idx_reg)
                6'h00:   addr_next = rxB.data;
                6'h01:   func_next = rxB.data;
                6'h02:   start_next[15:8] = rxB.data;
                6'h03:   start_next[7:0] = rxB.data;
                6'h04:   count_next[15:8] = rxB.data;
                6'h05:   count_next[7:0] = rxB.data;
                6'h06:   bcnt_next = rxB.data;
                default: begin
                  if (32'(dataPos[5:1]) < MAX_WORDS) begin
                    if (!dataPos[0]) buf_next[dataPos[5:1]][15:8] = rxB.data;
                    else buf_next[dataPos[5:1]][7:0] = rxB.data;
                  end
                end
              endcase
            end else if (chkPos == 9'h000) begin
              chk_next[7:0] = rxB.data;
            end else if (chkPos == 9'h001) begin
              chk_next[15:8] = rxB.data;
            end
            if (idx_reg == 6'h3f) bad_next = 1'b1;
            else idx_next = idx_reg + 6'h01;
          end
        end
      end
      mdci_pkg::ST_CHECK: begin
        idx_next = 6'h00;
        bad_next = 1'b0;
        if (frameOk) begin
          acc_next      = 1'b1;
          applyIdx_next = '0;
          state_next    = mdci_pkg::ST_APPLY;
        end else begin
          rej_next   = 1'b1;
          state_next = mdci_pkg::ST_RECV;
        end
      end
      mdci_pkg::ST_APPLY: begin
        applyIdx_next = applyIdx_reg + 1'b1;
        if (16'(applyIdx_reg) == count_reg - 16'h0001) begin
          step_next  = 5'h00;
          state_next = mdci_pkg::ST_CALC;
        end
      end
      mdci_pkg::ST_CALC: begin
        // A fresh check is built over the six echoed bytes before sending.
        crcInit   = (step_reg == 5'h00);
        crcValid  = 1'b1;
        crcByte   = replyByte(step_reg[3:0]);
        lrc_next  = (step_reg == 5'h00) ? crcByte : 8'(lrc_reg + crcByte);
        step_next = step_reg + 5'h01;
        if (step_reg == 5'h05) begin
          step_next    = 5'h00;
          state_next   = mdci_pkg::ST_REPLY;
          txValid_next = 1'b1;
          txChar_next  = asciiMode ? `MDCI_CHAR_START : addr_reg;
        end
      end
      mdci_pkg::ST_REPLY: begin
        if (txValid_reg && txReady) begin
          if (step_reg == lastStep) begin
            txValid_next = 1'b0;
            state_next   = mdci_pkg::ST_RECV;
          end else begin
            step_next   = step_reg + 5'h01;
            txChar_next = replyChar(step_reg + 5'h01);
          end
        end
      end
      default: state_next = mdci_pkg::ST_RECV;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg    <= mdci_pkg::ST_RECV;
      idx_reg      <= 6'h00;
      bad_reg      <= 1'b0;
      addr_reg     <= `MDCI_RESET_BYTE;
      func_reg     <= `MDCI_RESET_BYTE;
      start_reg    <= `MDCI_RESET_WORD;
      count_reg    <= `MDCI_RESET_WORD;
      bcnt_reg     <= `MDCI_RESET_BYTE;
      chk_reg      <= `MDCI_RESET_WORD;
      lrc_reg      <= `MDCI_RESET_BYTE;
      applyIdx_reg <= '0;
      step_reg     <= 5'h00;
      txChar_reg   <= `MDCI_RESET_BYTE;
      txValid_reg  <= 1'b0;
      acc_reg      <= 1'b0;
      rej_reg      <= 1'b0;
      for (int i = 0; i < MAX_WORDS; i++) buf_reg[i] <= `MDCI_RESET_WORD;
    end else begin
      state_reg    <= state_next;
      idx_reg      <= idx_next;
      bad_reg      <= bad_next;
      addr_reg     <= addr_next;
      func_reg     <= func_next;
      start_reg    <= start_next;
      count_reg    <= count_next;
      bcnt_reg     <= bcnt_next;
      chk_reg      <= chk_next;
      lrc_reg      <= lrc_next;
      applyIdx_reg <= applyIdx_next;
      step_reg     <= step_next;
      txChar_reg   <= txChar_next;
      txValid_reg  <= txValid_next;
      acc_reg      <= acc_next;
      rej_reg      <= rej_next;
      buf_reg      <= buf_next;
    end
  end

  // Drive-side register group: one buffered word lands per cycle in the apply state.
  mdci_pkg::mdci_drive_ctl_t drv_reg, drv_next;
  logic [15:0]               status_reg, status_next;
  logic                      pw_reg, pw_next;
  logic [15:0]               paddr_reg, paddr_next;
  logic [15:0]               pdata_reg, pdata_next;
  logic [15:0]               wAddr;
  logic [15:0]               wData;

  assign wAddr = start_reg + 16'(applyIdx_reg);
  assign wData = buf_reg[applyIdx_reg];

  always_comb begin
    drv_next            = drv_reg;
    drv_next.faultReset = 1'b0;
    pw_next             = 1'b0;
    paddr_next          = paddr_reg;
    pdata_next          = pdata_reg;
    status_next         = {warningCode, faultCode};
    if (state_reg == mdci_pkg::ST_APPLY) begin
      case (wAddr)
        `MDCI_ADDR_COMMAND_WORD: begin
          drv_next.commandWord = wData;
          case (wData[`MDCI_CMD_RUN_LSB +: 2])
            2'b01:   begin drv_next.runEnable = 1'b0; drv_next.inchRun = 1'b0; end
            2'b10:   begin drv_next.runEnable = 1'b1; drv_next.inchRun = 1'b0; end
            2'b11:   begin drv_next.runEnable = 1'b1; drv_next.inchRun = 1'b1; end
            default: drv_next.runEnable = drv_reg.runEnable;
          endcase
          case (wData[`MDCI_CMD_DIR_LSB +: 2])
            2'b01:   drv_next.backwardRotation = 1'b0;
            2'b10:   drv_next.backwardRotation = 1'b1;
            2'b11:   drv_next.backwardRotation = !drv_reg.backwardRotation;
            default: drv_next.backwardRotation = drv_reg.backwardRotation;
          endcase
          if (wData[`MDCI_CMD_FIELD_ENABLE]) begin
            drv_next.rampSet   = wData[`MDCI_CMD_RAMP_LSB +: 2];
            drv_next.stepSpeed = wData[`MDCI_CMD_STEP_LSB +: 4];
          end
        end
        `MDCI_ADDR_FREQ_SETPOINT: drv_next.frequencySetpoint = wData;
        `MDCI_ADDR_CONTROL_FLAGS: begin
          drv_next.externalFault = wData[`MDCI_FLAG_EXT_FAULT];
          drv_next.faultReset    = wData[`MDCI_FLAG_FAULT_RESET];
          drv_next.baseBlock     = wData[`MDCI_FLAG_BASE_BLOCK];
        end
        // The status word is read-only; writes to it are dropped.
        `MDCI_ADDR_STATUS_WORD: pw_next = 1'b0;
        default: begin
          pw_next    = 1'b1;
          paddr_next = wAddr;
          pdata_next = wData;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      drv_reg    <= '0;
      status_reg <= `MDCI_RESET_WORD;
      pw_reg     <= 1'b0;
      paddr_reg  <= `MDCI_RESET_WORD;
      pdata_reg  <= `MDCI_RESET_WORD;
    end else begin
      drv_reg    <= drv_next;
      status_reg <= status_next;
      pw_reg     <= pw_next;
      paddr_reg  <= paddr_next;
      pdata_reg  <= pdata_next;
    end
  end

  assign txChar        = txChar_reg;
  assign txValid       = txValid_reg;
  assign driveCtl      = drv_reg;
  assign statusWord    = status_reg;
  assign paramWrite    = pw_reg;
  assign paramGroup    = paddr_reg[15:8];
  assign paramIndex    = paddr_reg[7:0];
  assign paramData     = pdata_reg;
  assign frameAccepted = acc_reg;
  assign frameRejected = rej_reg;

endmodule
`default_nettype wire

// ---- verif/mdci_check_monitor.sv ----
// Concurrent checks on the command interface ports.
`timescale 1ns/1ps
`default_nettype none
module mdci_check_monitor (
  // Clock and reset
  input wire logic                      sys_clk,
  input wire logic                      reset,
  // Streams
  input wire logic                      rxCharValid,
  input wire logic                      rxGap,
  input wire logic [7:0]                txChar,
  input wire logic                      txValid,
  input wire logic                      txReady,
  // Drive side
  input wire logic [7:0]                warningCode,
  input wire logic [7:0]                faultCode,
  input wire mdci_pkg::mdci_drive_ctl_t driveCtl,
  input wire logic [15:0]               statusWord,
  input wire logic                      frameAccepted,
  input wire logic                      frameRejected
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_status_lag: assert property (!$past(reset) |->
    statusWord == {$past(warningCode), $past(faultCode)}) else $error("status lag");
  a_outcome_excl: assert property (!(frameAccepted && frameRejected))
    else $error("both outcomes");
  a_outcome_cause: assert property (frameAccepted || frameRejected |->
    $past(rxGap, 3) || $past(rxCharValid, 3)) else $error("outcome without end");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txChar))
    else $error("reply char dropped");
  a_reply_bound: assert property (frameAccepted |-> ##[1:80] txValid)
    else $error("no reply");
  a_no_reply: assert property (frameRejected |=> !txValid [*8])
    else $error("reply to bad frame");
  a_reset_pulse: assert property (driveCtl.faultReset |=> !driveCtl.faultReset)
    else $error("fault reset held");
  a_field_gate: assert property ($changed(driveCtl.rampSet) ||
    $changed(driveCtl.stepSpeed) |-> ##[0:1] driveCtl.commandWord[12])
    else $error("ungated field load");
  c_accept: cover property (frameAccepted);
  c_reject: cover property (frameRejected);
  c_stall: cover property (txValid && !txReady);
endmodule
bind mdci_top mdci_check_monitor u_mon (.sys_clk, .reset, .rxCharValid, .rxGap, .txChar,
  .txValid, .txReady, .warningCode, .faultCode, .driveCtl, .statusWord, .frameAccepted,
  .frameRejected);
`default_nettype wire

// ---- verif/mdci_master_model.sv ----
// Serial master model: builds and sends write frames, sinks the reply.
`timescale 1ns/1ps
`default_nettype none
module mdci_master_model (
  // Clock
  input wire logic        sys_clk,
  // To the slave
  output logic      [7:0] rxChar,
  output logic            rxCharValid,
  output logic            rxGap,
  // From the slave
  input wire logic  [7:0] txChar,
  input wire logic        txValid,
  output logic            txReady
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  initial begin
    rxChar = 8'h00;
    rxCharValid = 1'b0;
    rxGap = 1'b0;
  end
  // A slow sink stalls every other cycle to exercise the reply hold.
  always @(negedge sys_clk) txReady <= slow ? !txReady : 1'b1;
  always @(posedge sys_clk) if (txValid && txReady) got.push_back(txChar);
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] n);
    return n < 4'ha ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task automatic put(input logic [7:0] c);
    @(negedge sys_clk);
    rxChar = c;
    rxCharValid = 1'b1;
    @(negedge sys_clk);
    rxCharValid = 1'b0;
    rxChar = ~c;
  endtask
  task automatic frame(input logic ascii, input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    logic [7:0]  s;
    c = crc16(b) ^ {15'h0000, bad};
    s = 8'h00;
    if (ascii) begin
      put(8'h3a);
      foreach (b[i]) begin
        put(hx(b[i][7:4]));
        put(hx(b[i][3:0]));
        s = s + b[i];
      end
      s = (8'h00 - s) ^ {7'h00, bad};
      put(hx(s[7:4]));
      put(hx(s[3:0]));
      put(8'h0d);
      put(8'h0a);
    end else begin
      foreach (b[i]) put(b[i]);
      put(c[7:0]);
      put(c[15:8]);
      @(negedge sys_clk);
      rxGap = 1'b1;
      @(negedge sys_clk);
      rxGap = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/mdci_top_tb.sv ----
// Self-checking bench for the drive command interface.
`timescale 1ns/1ps
`default_nettype none
module mdci_top_tb;
  logic sys_clk = 1'b0, reset = 1'b1, ascii = 1'b0, frPulse = 1'b0;
  logic [7:0] txChar, rxChar, pg, pi, warn = 8'h00, flt = 8'h00;
  logic txValid, txReady, rxCharValid, rxGap, pw, acc, rej;
  logic [15:0] statusWord, pd;
  mdci_pkg::mdci_drive_ctl_t ctl;
  int n_fail = 0, total_checks = 0, cyc = 0, nPw = 0;
  always #4 sys_clk = ~sys_clk;
  mdci_top dut (.sys_clk, .reset, .asciiMode(ascii), .stationAddress(8'h01), .rxChar,
    .rxCharValid, .rxGap, .txChar, .txValid, .txReady, .warningCode(warn), .faultCode(flt),
    .driveCtl(ctl), .statusWord, .paramWrite(pw), .paramGroup(pg), .paramIndex(pi),
    .paramData(pd), .frameAccepted(acc), .frameRejected(rej));
  mdci_master_model m (.sys_clk, .rxChar, .rxCharValid, .rxGap, .txChar, .txValid, .txReady);
  always @(posedge sys_clk) if (ctl.faultReset) frPulse = 1'b1;
  always @(posedge sys_clk) nPw += pw;
  always @(posedge sys_clk) if (++cyc == 20000) begin
    n_fail++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] w[$], input logic bad, ok);
    logic [7:0]  b[$], e[$];
    logic [15:0] c;
    b = {8'h01, 8'h10, a[15:8], a[7:0], 8'h00, 8'(w.size()), 8'(2 * w.size())};
    foreach (w[i]) b = {b, w[i][15:8], w[i][7:0]};
    frPulse = 1'b0;
    m.got.delete();
    m.frame(ascii, b, bad);
    repeat (100) if (!(acc || rej)) @(negedge sys_clk);
    chk("accepted", 16'(acc), 16'(ok));
    repeat (300) if (m.got.size() < (ascii ? 17 : 8)) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    b = b[0:5];
    c = m.crc16(b);
    if (ascii) begin
      b.push_back(-b.sum());
      foreach (b[i]) e = {e, m.hx(b[i][7:4]), m.hx(b[i][3:0])};
      e = {8'h3a, e, 8'h0d, 8'h0a};
    end else e = {b, c[7:0], c[15:8]};
    chk("reply size", 16'(m.got.size()), ok ? (ascii ? 16'h0011 : 16'h0008) : 16'h0000);
    if (ok) foreach (e[i]) chk("reply char", 16'(m.got[i]), 16'(e[i]));
    $display("frame test to %h done", a);
  endtask
  initial begin
    logic [15:0] w[$];
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    chk("status", statusWord, 16'h0000);
    wr(16'h2000, {16'h1fe3, 16'h1388}, 1'b0, 1'b1);
    chk("run", 16'({ctl.runEnable, ctl.inchRun, ctl.backwardRotation}), 16'h0007);
    chk("ramp", 16'({ctl.rampSet, ctl.stepSpeed}), 16'h003f);
    chk("freq", ctl.frequencySetpoint, 16'h1388);
    m.slow = 1'b1;
    wr(16'h2000, {16'h0a51}, 1'b0, 1'b1);
    chk("stop", 16'({ctl.runEnable, ctl.inchRun, ctl.backwardRotation}), 16'h0000);
    chk("held", 16'({ctl.rampSet, ctl.stepSpeed}), 16'h003f);
    wr(16'h2000, {16'h0030}, 1'b0, 1'b1);
    chk("toggle", 16'(ctl.backwardRotation), 16'h0001);
    ascii = 1'b1;
    wr(16'h2002, {16'h0007}, 1'b0, 1'b1);
    chk("flags", 16'({ctl.externalFault, ctl.baseBlock, frPulse}), 16'h0007);
    wr(16'h2001, {16'h0001}, 1'b1, 1'b0);
    ascii = 1'b0;
    wr(16'h2001, {16'h0001}, 1'b1, 1'b0);
    chk("freq kept", ctl.frequencySetpoint, 16'h1388);
    repeat (21) w.push_back(16'h0000);
    wr(16'h2000, w, 1'b0, 1'b0);
    wr(16'h040a, {16'h1388, 16'h0fa0}, 1'b0, 1'b1);
    chk("param addr", {pg, pi}, 16'h040b);
    chk("param data", pd, 16'h0fa0);
    chk("param writes", 16'(nPw), 16'h0002);
    warn = 8'h5a;
    flt = 8'ha5;
    repeat (2) @(negedge sys_clk);
    chk("status", statusWord, 16'h5aa5);
    print_verdict();
  end
endmodule
`default_nettype wire
